// ===== hw/ppao_regs.svh
// Purpose: Constants for the port pin alternate override block
// Assumes: One 8-pin port, synchronous active-high reset
// Notes: Pull-up default pattern is {dir, out, disable} = 3'b010
`ifndef PPAO_REGS_SVH
`define PPAO_REGS_SVH
`define PPAO_NPINS 8
`define PPAO_PU_PATTERN 3'b010
`define PPAO_SYNC_STAGES 2
`define PPAO_RST_BYTE 8'h00
`endif

// ===== hw/ppao_pkg.sv
// Purpose: Types for the port pin alternate override block
// Assumes: Eight pins per port
// Notes: Each override field is one bit per pin
package ppao_pkg;
    typedef struct packed {
        logic [7:0] pullup_ovr_en;
        logic [7:0] pullup_ovr_val;
        logic [7:0] dir_ovr_en;
        logic [7:0] dir_ovr_val;
        logic [7:0] outval_ovr_en;
        logic [7:0] outval_ovr_val;
        logic [7:0] toggle_ovr_en;
        logic [7:0] inen_ovr_en;
        logic [7:0] inen_ovr_val;
    } ppao_ovr_t;
    typedef enum logic [1:0] {
        PPAO_ACTIVE = 2'h0,
        PPAO_IDLE = 2'h1,
        PPAO_DEEP = 2'h3,
        PPAO_NOISE = 2'h2
    } ppao_mode_t;
endpackage

// ===== hw/ppao_pin_ctl.sv
// Purpose: Per-pin pad control from register bits and overrides
// Assumes: Override fields already combined per pin
// Notes: Purely combinational; the top registers the results
`timescale 1ns/1ps
`include "ppao_regs.svh"
module ppao_pin_ctl (
    // Register bits
    input wire logic dir_bit_i,
    input wire logic out_bit_i,
    input wire logic global_pullup_disable_i,
    input wire logic sleep_i,
    // Overrides
    input wire logic pullup_ovr_en_i,
    input wire logic pullup_ovr_val_i,
    input wire logic dir_ovr_en_i,
    input wire logic dir_ovr_val_i,
    input wire logic outval_ovr_en_i,
    input wire logic outval_ovr_val_i,
    input wire logic inen_ovr_en_i,
    input wire logic inen_ovr_val_i,
    // Pad controls
    output logic pullup_o,
    output logic drv_en_o,
    output logic drv_val_o,
    output logic inen_o
);
    always_comb begin
        if (pullup_ovr_en_i) begin
            pullup_o = pullup_ovr_val_i;
        end else begin
            pullup_o = ({dir_bit_i, out_bit_i, global_pullup_disable_i}
                == `PPAO_PU_PATTERN);
        end
        drv_en_o = dir_ovr_en_i ? dir_ovr_val_i : dir_bit_i;
        // Level is only meaningful while driving
        drv_val_o = drv_en_o &
            (outval_ovr_en_i ? outval_ovr_val_i : out_bit_i);
        inen_o = inen_ovr_en_i ? inen_ovr_val_i : ~sleep_i;
    end
endmodule

// ===== hw/ppao_port.sv
// Purpose: Port A with alternate-function override muxing
// Assumes: Pad input after Schmitt stage arrives as pad_in_i
// Notes: Outputs registered, so pad controls lag inputs by one cycle
`timescale 1ns/1ps
`include "ppao_regs.svh"
module ppao_port
    import ppao_pkg::*;
#(
    parameter int NPINS = `PPAO_NPINS
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Port-wide strobes and data
    input wire logic [7:0] wdata_i,
    input wire logic write_out_strobe_i,
    input wire logic write_dir_strobe_i,
    input wire logic write_in_strobe_i,
    input wire logic read_out_strobe_i,
    input wire logic read_dir_strobe_i,
    input wire logic read_pin_strobe_i,
    output logic [7:0] rdata_o,
    // Chip-wide controls
    input wire logic global_pullup_disable_i,
    input wire ppao_mode_t sleep_mode_i,
    // Generic override bundle from other modules
    input wire ppao_ovr_t ext_ovr_i,
    input wire logic ext_claim_i,
    // First-port alternate sources
    input wire logic [7:0] pin_change_mask_i,
    input wire logic pin_change_group_en_i,
    input wire logic [7:0] conv_digin_disable_i,
    // Pad side
    input wire logic [7:0] pad_in_i,
    output logic [7:0] pullup_o,
    output logic [7:0] drv_en_o,
    output logic [7:0] drv_val_o,
    output logic [7:0] inen_o,
    // To alternate-function modules
    output logic [7:0] raw_digital_in_o,
    output logic [7:0] pin_change_src_o,
    output logic [7:0] conv_chan_o,
    output logic [7:0] in_bit_o
);
    logic [7:0] dir_bit_q;
    logic [7:0] out_bit_q;
    logic [7:0] sync1_q;
    logic [7:0] in_bit_q;
    logic [7:0] rdata_q;
    logic [7:0] pullup_q;
    logic [7:0] drv_en_q;
    logic [7:0] drv_val_q;
    logic [7:0] inen_q;
    logic [7:0] raw_q;
    logic sleep;
    ppao_ovr_t ovr;
    logic [7:0] pullup_d;
    logic [7:0] drv_en_d;
    logic [7:0] drv_val_d;
    logic [7:0] inen_d;
    logic [7:0] pc_hit;

    // Only deep mode clamps inputs; idle and noise-reduce keep them live
    assign sleep = (sleep_mode_i == PPAO_DEEP);
    assign pc_hit = pin_change_mask_i & {8{pin_change_group_en_i}};

    // Merge: first-port sources own the input enable, others via claim
    always_comb begin
        ovr = '0;
        if (ext_claim_i) begin
            ovr = ext_ovr_i;
        end
        ovr.inen_ovr_en = ovr.inen_ovr_en | pc_hit
            | conv_digin_disable_i;
        ovr.inen_ovr_val = ovr.inen_ovr_val | pc_hit;
    end

    // One control slice per pin, each with its own override bits
    for (genvar n = 0; n < NPINS; n++) begin : g_pin
        ppao_pin_ctl u_ctl (
            .dir_bit_i(dir_bit_q[n]),
            .out_bit_i(out_bit_q[n]),
            .global_pullup_disable_i(global_pullup_disable_i),
            .sleep_i(sleep),
            .pullup_ovr_en_i(ovr.pullup_ovr_en[n]),
            .pullup_ovr_val_i(ovr.pullup_ovr_val[n]),
            .dir_ovr_en_i(ovr.dir_ovr_en[n]),
            .dir_ovr_val_i(ovr.dir_ovr_val[n]),
            .outval_ovr_en_i(ovr.outval_ovr_en[n]),
            .outval_ovr_val_i(ovr.outval_ovr_val[n]),
            .inen_ovr_en_i(ovr.inen_ovr_en[n]),
            .inen_ovr_val_i(ovr.inen_ovr_val[n]),
            .pullup_o(pullup_d[n]),
            .drv_en_o(drv_en_d[n]),
            .drv_val_o(drv_val_d[n]),
            .inen_o(inen_d[n])
        );
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dir_bit_q <= `PPAO_RST_BYTE;
        end else if (write_dir_strobe_i) begin
            dir_bit_q <= wdata_i;
        end
    end

    // Write beats pin-write toggle; coinciding toggles invert only once
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_bit_q <= `PPAO_RST_BYTE;
        end else if (write_out_strobe_i) begin
            out_bit_q <= wdata_i ^ ovr.toggle_ovr_en;
        end else begin
            out_bit_q <= out_bit_q ^ (ovr.toggle_ovr_en
                | (write_in_strobe_i ? wdata_i : 8'h00));
        end
    end

    // Clamped input reads low, as the pad gate forces it
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            raw_q <= `PPAO_RST_BYTE;
            sync1_q <= `PPAO_RST_BYTE;
            in_bit_q <= `PPAO_RST_BYTE;
        end else begin
            raw_q <= pad_in_i & inen_q;
            sync1_q <= pad_in_i & inen_q;
            in_bit_q <= sync1_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rdata_q <= `PPAO_RST_BYTE;
        end else if (read_pin_strobe_i) begin
            rdata_q <= in_bit_q;
        end else if (read_dir_strobe_i) begin
            rdata_q <= dir_bit_q;
        end else if (read_out_strobe_i) begin
            rdata_q <= out_bit_q;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    // Reset leaves pins tri-stated, no pull-up, input enabled
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            pullup_q <= 8'h00;
            drv_en_q <= 8'h00;
            drv_val_q <= 8'h00;
            inen_q <= 8'hFF;
        end else begin
            pullup_q <= pullup_d;
            drv_en_q <= drv_en_d;
            drv_val_q <= drv_val_d;
            inen_q <= inen_d;
        end
    end

    // Analog path is not modelled here; pad connects outside the block
    assign pullup_o = pullup_q;
    assign drv_en_o = drv_en_q;
    assign drv_val_o = drv_val_q;
    assign inen_o = inen_q;
    assign rdata_o = rdata_q;
    assign raw_digital_in_o = raw_q;
    assign pin_change_src_o = raw_q;
    assign conv_chan_o = raw_q;
    assign in_bit_o = in_bit_q;

    property p_pullup_ovr;
        @(posedge clk_i) disable iff (srst_i)
        (ovr.pullup_ovr_en[0]) |=>
            (pullup_o[0] == $past(ovr.pullup_ovr_val[0]));
    endproperty
    a_pullup_ovr: assert property (p_pullup_ovr)
        else $error("pull-up override not applied");

    property p_pullup_def;
        @(posedge clk_i) disable iff (srst_i)
        (!ovr.pullup_ovr_en[1]) |=> (pullup_o[1] ==
            ($past({dir_bit_q[1], out_bit_q[1], global_pullup_disable_i})
            == 3'b010));
    endproperty
    a_pullup_def: assert property (p_pullup_def)
        else $error("default pull-up wrong");

    property p_dir;
        @(posedge clk_i) disable iff (srst_i)
        1'b1 |=> (drv_en_o[2] == ($past(ovr.dir_ovr_en[2]) ?
            $past(ovr.dir_ovr_val[2]) : $past(dir_bit_q[2])));
    endproperty
    a_dir: assert property (p_dir)
        else $error("driver enable wrong");

    property p_val;
        @(posedge clk_i) disable iff (srst_i)
        (drv_en_d[3] && !ovr.outval_ovr_en[3]) |=>
            (drv_val_o[3] == $past(out_bit_q[3]));
    endproperty
    a_val: assert property (p_val)
        else $error("driven level not from output bit");

    property p_val_ovr;
        @(posedge clk_i) disable iff (srst_i)
        (drv_en_d[0] && ovr.outval_ovr_en[0]) |=>
            (drv_val_o[0] == $past(ovr.outval_ovr_val[0]));
    endproperty
    a_val_ovr: assert property (p_val_ovr)
        else $error("value override not applied");

    property p_inen_ovr;
        @(posedge clk_i) disable iff (srst_i)
        ovr.inen_ovr_en[7] |=>
            (inen_o[7] == $past(ovr.inen_ovr_val[7]));
    endproperty
    a_inen_ovr: assert property (p_inen_ovr)
        else $error("input-enable override not applied");

    property p_toggle;
        @(posedge clk_i) disable iff (srst_i)
        (ovr.toggle_ovr_en[4] && !write_out_strobe_i && !write_in_strobe_i)
            |=> (out_bit_q[4] != $past(out_bit_q[4]));
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle override ignored");

    sequence s_deep_quiet;
        sleep && ovr.inen_ovr_en == 8'h00;
    endsequence
    property p_clamp;
        @(posedge clk_i) disable iff (srst_i)
        s_deep_quiet |=> (inen_o == 8'h00) ##1 (raw_digital_in_o == 8'h00);
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("sleep clamp failed");

    property p_pc_inen;
        @(posedge clk_i) disable iff (srst_i)
        pc_hit[5] |=> inen_o[5];
    endproperty
    a_pc_inen: assert property (p_pc_inen)
        else $error("pin change did not keep input enabled");

    property p_unclaimed;
        @(posedge clk_i) disable iff (srst_i)
        (!ext_claim_i && !dir_bit_q[6]) |=> !drv_en_o[6];
    endproperty
    a_unclaimed: assert property (p_unclaimed)
        else $error("unclaimed pin driven");
endmodule

// ===== tb/ppao_alt_model.sv
// Purpose: Alternate-function modules on the far side of the port
// Assumes: Bench sets requests through set_req just after a clock edge
// Notes: Claim is dropped while reset is high
`timescale 1ns/1ps
module ppao_alt_model
    import ppao_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // From port
    input wire logic [7:0] raw_digital_in_i,
    // To port
    output ppao_ovr_t ovr_o,
    output logic claim_o,
    output logic [7:0] pc_mask_o,
    output logic pc_grp_en_o,
    output logic [7:0] conv_dis_o,
    // Synchronised copy for own use
    output logic [7:0] synced_o
);
    ppao_ovr_t ovr_q;
    logic claim_q;
    logic [7:0] meta_q;
    // Overrides originate here; the port only applies them
    assign ovr_o = ovr_q;
    assign claim_o = claim_q & ~srst_i;
    // Raw input is a single port-clock sample of the pad
    always_ff @(posedge clk_i) begin
        meta_q <= raw_digital_in_i;
        synced_o <= meta_q;
    end
    task automatic set_req(input ppao_ovr_t o, input logic c,
                           input logic [7:0] m, input logic g,
                           input logic [7:0] d);
        ovr_q = o;
        claim_q = c;
        pc_mask_o = m;
        pc_grp_en_o = g;
        conv_dis_o = d;
    endtask
endmodule

// ===== tb/ppao_port_bench.sv
// Purpose: Self-checking bench for the port override block
// Assumes: Outputs registered one cycle after inputs
// Notes: Random traffic; raw input checked every cycle against the previous input enable
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("BAD %s exp %h got %h", n, e, g); \
    end \
end
module ppao_port_bench;
    import ppao_pkg::*;
    typedef struct {
        int cyc;
        logic [7:0] pu, de, dv, ie, rd, pad;
        logic rp;
    } ppao_exp_t;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] wdata = 8'h00;
    logic wr_out = 1'b0, wr_dir = 1'b0, wr_in = 1'b0;
    logic rd_out = 1'b0, rd_dir = 1'b0, rd_pin = 1'b0, gpd = 1'b0;
    logic [7:0] raw_x0, raw_x1 = 8'h00, raw_x2 = 8'h00;
    ppao_mode_t mode = PPAO_ACTIVE;
    logic [7:0] pad = 8'h00;
    logic [7:0] rdata, pu, de, dv, ie, raw, pcs, cch, inb, syn, mask, conv;
    logic grp, claim;
    ppao_ovr_t ovr;
    ppao_exp_t q[$];
    ppao_exp_t e_m;
    int n_errors = 0, samples_checked = 0, cyc = 0;
    int seed = 32'h4A57;
    logic [7:0] dir_m = 8'h00, out_m = 8'h00, ie_prev = 8'hFF;
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) cyc <= cyc + 1;
    ppao_alt_model alt_u (.clk_i, .srst_i, .raw_digital_in_i(raw),
        .ovr_o(ovr), .claim_o(claim), .pc_mask_o(mask),
        .pc_grp_en_o(grp), .conv_dis_o(conv), .synced_o(syn));
    ppao_port #(.NPINS(8)) dut_u (.clk_i, .srst_i, .wdata_i(wdata),
        .write_out_strobe_i(wr_out), .write_dir_strobe_i(wr_dir),
        .write_in_strobe_i(wr_in), .read_out_strobe_i(rd_out),
        .read_dir_strobe_i(rd_dir), .read_pin_strobe_i(rd_pin),
        .rdata_o(rdata), .global_pullup_disable_i(gpd),
        .sleep_mode_i(mode), .ext_ovr_i(ovr), .ext_claim_i(claim),
        .pin_change_mask_i(mask), .pin_change_group_en_i(grp),
        .conv_digin_disable_i(conv), .pad_in_i(pad), .pullup_o(pu),
        .drv_en_o(de), .drv_val_o(dv), .inen_o(ie),
        .raw_digital_in_o(raw), .pin_change_src_o(pcs),
        .conv_chan_o(cch), .in_bit_o(inb));
    task automatic results();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // One random cycle; expectation uses register bits before the edge
    task automatic step(input logic quiet);
        logic [95:0] r;
        logic [31:0] r2;
        ppao_ovr_t ev;
        logic [7:0] pc, ien, iev, m, d;
        ppao_exp_t e;
        @(posedge clk_i);
        #1;
        r = {$random(seed), $random(seed), $random(seed)};
        r2 = $random(seed);
        // Quiet deep-sleep cycles reach the clamp with no override
        if (quiet) begin
            r = '0;
            r[76:75] = PPAO_DEEP;
        end
        // First-port terms only when unclaimed; mixing them is undefined
        m = r[72] ? 8'h00 : r[87:80];
        d = r[72] ? 8'h00 : r[95:88];
        alt_u.set_req(r[71:0], r[72], m, r[73], d);
        gpd = r[74];
        mode = ppao_mode_t'(r[76:75]);
        wdata = r2[7:0];
        pad = r2[15:8];
        {wr_dir, wr_out, wr_in, rd_dir, rd_out, rd_pin} = 6'd1 << r2[18:16];
        // Model output nets settle later; use the values just requested
        ev = r[72] ? r[71:0] : 72'h0;
        pc = m & {8{r[73]}};
        ien = ev.inen_ovr_en | pc | d;
        iev = ev.inen_ovr_val | pc;
        e.cyc = cyc + 1;
        e.pu = (ev.pullup_ovr_en & ev.pullup_ovr_val)
             | (~ev.pullup_ovr_en & ~dir_m & out_m & ~{8{gpd}});
        e.de = (ev.dir_ovr_en & ev.dir_ovr_val) | (~ev.dir_ovr_en & dir_m);
        e.dv = e.de & ((ev.outval_ovr_en & ev.outval_ovr_val)
             | (~ev.outval_ovr_en & out_m));
        e.ie = (ien & iev) | (~ien & {8{mode != PPAO_DEEP}});
        e.rd = rd_dir ? dir_m : (rd_out ? out_m : 8'h00);
        e.rp = rd_pin;
        e.pad = pad;
        q.push_back(e);
        if (wr_dir) dir_m = wdata;
        out_m = wr_out ? wdata ^ ev.toggle_ovr_en
              : out_m ^ (ev.toggle_ovr_en | (wr_in ? wdata : 8'h00));
    endtask
    always @(negedge clk_i) begin
        if (q.size() > 0 && q[0].cyc == cyc) begin
            e_m = q.pop_front();
            // Raw input gates the pad with the previous input enable
            raw_x0 = e_m.pad & ie_prev;
            `CHK("pullup", e_m.pu, pu)
            `CHK("drv_en", e_m.de, de)
            `CHK("drv_val", e_m.dv, dv)
            `CHK("inen", e_m.ie, ie)
            `CHK("rdata", e_m.rp ? raw_x2 : e_m.rd, rdata)
            `CHK("raw", raw_x0, raw)
            `CHK("pc_src", raw_x0, pcs)
            `CHK("conv_chan", raw_x0, cch)
            `CHK("in_bit", raw_x1, inb)
            `CHK("synced", raw_x2, syn)
            ie_prev = e_m.ie;
            raw_x2 = raw_x1;
            raw_x1 = raw_x0;
        end
    end
    initial begin
        #50000;
        n_errors++;
        results();
    end
    initial begin
        alt_u.set_req('0, 1'b0, 8'h00, 1'b0, 8'h00);
        repeat (16) @(posedge clk_i);
        #1;
        `CHK("rst_pullup", 8'h00, pu)
        `CHK("rst_drv_en", 8'h00, de)
        `CHK("rst_inen", 8'hFF, ie)
        srst_i = 1'b0;
        for (int i = 0; i < 3000; i++) step(i % 64 < 4);
        repeat (3) @(posedge clk_i);
        `CHK("drain", 0, q.size())
        results();
    end
endmodule
